// ==== hdl/cts_regs.vh ====
`ifndef CTS_REGS_VH
`define CTS_REGS_VH
// Register byte offsets
`define CTS_OFF_CTRL      8'h00
`define CTS_OFF_HIGH      8'h04
`define CTS_OFF_LOW       8'h08
`define CTS_OFF_MINMAX    8'h0C
`define CTS_OFF_SEQ       8'h10
`define CTS_OFF_RESID     8'h14
`define CTS_OFF_DELAY     8'h18
`define CTS_OFF_EVSEL     8'h1C
`define CTS_OFF_STATUS    8'h20
`define CTS_OFF_ISTAT     8'h24
`define CTS_OFF_IMASK     8'h28
`define CTS_OFF_ALMCNT    8'h2C
`define CTS_OFF_BLKCNT    8'h30
`define CTS_OFF_HSEL      8'h34
`define CTS_OFF_HTIME     8'h38
`define CTS_OFF_HINFO     8'h3C
`define CTS_OFF_HPH12     8'h40
`define CTS_OFF_HPH3R     8'h44
`define CTS_OFF_HSEQ      8'h48
`define CTS_OFF_HTTA      8'h4C
// Control register bit positions
`define CTS_CTRL_EN       0
`define CTS_CTRL_RESEN    1
`define CTS_CTRL_CNTCLR   2
// Reset values; currents in 0.01 x In, ratios in 0.01 %, delay in 5 ms steps
`define CTS_RST_CTRL      3'h1
`define CTS_RST_HIGH      16'h0078
`define CTS_RST_LOW       16'h000A
`define CTS_RST_MINMAX    14'h03E8
`define CTS_RST_SEQ       14'h1324
`define CTS_RST_RESID     16'h000A
`define CTS_RST_DELAY     19'h00064
`define CTS_RST_EVSEL     8'hFF
// Ratio full scale (100.00 %)
`define CTS_RATIO_FULL    14'h2710
// Event indices
`define CTS_EV_ALMON      0
`define CTS_EV_ALMOFF     1
`define CTS_EV_BLKON      2
`define CTS_EV_BLKOFF     3
// Timing: program cycle and delay step both 5 ms
`define CTS_CLK_PERIOD_NS 10
`define CTS_STEP_MS       5
`define CTS_STEP_CYC      (`CTS_STEP_MS * 1000000 / `CTS_CLK_PERIOD_NS)
// History depth
`define CTS_HIST_DEPTH    12
`endif

// ==== hdl/cts_ratio_cmp.v ====
`include "cts_regs.vh"
`default_nettype none
// Ratio test num/den against a threshold in 0.01 % without division
module cts_ratio_cmp #(
  parameter IW = 16,
  parameter TW = 14,
  parameter GE = 0
) (
  // Operands
  input  wire [IW-1:0] num,
  input  wire [IW-1:0] den,
  input  wire [TW-1:0] thr,
  // Result
  output wire          meets
);
  wire [IW+TW-1:0] lhs;
  wire [IW+TW-1:0] rhs;

  // Cross multiply; a zero denominator never meets
  assign lhs = num * `CTS_RATIO_FULL;
  assign rhs = den * thr;
  assign meets = (den != {IW{1'b0}}) & ((GE != 0) ? (lhs >= rhs) : (lhs <= rhs));
endmodule
`default_nettype wire

// ==== hdl/cts_history.v ====
`include "cts_regs.vh"
`default_nettype none
// Ring of the most recent records; index 0 reads the newest
module cts_history #(
  parameter RW    = 156,
  parameter DEPTH = `CTS_HIST_DEPTH
) (
  // Clock and reset
  input  wire          sys_clk,
  input  wire          rst_n,
  // Write side
  input  wire          wrEn,
  input  wire [RW-1:0] wrData,
  // Read side
  input  wire [3:0]    rdIdx,
  output wire [RW-1:0] rdData,
  output wire [3:0]    entries
);
  reg  [3:0]    wrPtr_q;
  reg  [3:0]    cnt_q;
  wire [RW-1:0] mem [0:DEPTH-1];
  wire [4:0]    back;
  wire [3:0]    phys;
  genvar g;
  // Depth at the pointer widths, so the ring arithmetic stays exact
  localparam [4:0] DEPTH_B = DEPTH;
  localparam [3:0] DEPTH_N = DEPTH;

  // Oldest entry is overwritten once the ring is full
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPtr_q <= 4'h0;
      cnt_q   <= 4'h0;
    end
    else if (wrEn)
    begin
      wrPtr_q <= (wrPtr_q == DEPTH - 1) ? 4'h0 : wrPtr_q + 4'h1;
      if (cnt_q != DEPTH)
        cnt_q <= cnt_q + 4'h1;
    end
  end

  generate
    for (g = 0; g < DEPTH; g = g + 1)
    begin : gEnt
      reg [RW-1:0] ent_q;
      always @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
          ent_q <= {RW{1'b0}};
        else if (wrEn && wrPtr_q == g)
          ent_q <= wrData;
      end
      assign mem[g] = ent_q;
    end
  endgenerate

  // Newest sits one below the write pointer, wrapping modulo depth
  assign back = {1'b0, wrPtr_q} + DEPTH_B - 5'h01 - {1'b0, rdIdx};
  assign phys = (back >= DEPTH_B) ? back[3:0] - DEPTH_N : back[3:0];
  assign rdData = (rdIdx < cnt_q) ? mem[phys] : {RW{1'b0}};
  assign entries = cnt_q;
endmodule
`default_nettype wire

// ==== hdl/cts_supervision.v ====
// Overview of operation
// - Fault with all conditions starts delay; alarm only if it persists to the end.
// - No activation while any phase current exceeds the overcurrent inhibit limit.
// - No activation when every phase current is below the minimum current limit.
// - With residual checking, compare calculated phase sum with measured residual.
// - With residual checking, no activation while mismatch stays below its limit.
// - Alarm for any qualifying condition, primary or secondary side alike.
// - Four events: alarm on, alarm off, block on, block off.
// - Per event, software selects whether rising, falling or both are reported.
// - Every reported event carries a time stamp.
// - Cumulative alarm and block counters, clearable on request.
// - History keeps the twelve newest records, dropping the oldest.
// - A record is captured on each asserting event, alarm on or block on.
// - Record holds time, event, currents, time to alarm, fault code, group.
// - Activation needs negative/positive sequence ratio at or above threshold.
// - Activation needs min/max phase current ratio at or below threshold.
// - Block present at pick-up gives blocked indication and stops the timer.
// - Alarm delay settable in 5 ms steps, default 0.5 s.
//
// Implementation choices: the placing of the registers and the strobed register port.
`include "cts_regs.vh"
`default_nettype none
module cts_supervision #(
  parameter IW       = 16,
  parameter DW       = 19,
  parameter STEP_CYC = `CTS_STEP_CYC
) (
  // Clock and reset
  input  wire          sys_clk,
  input  wire          rst_n,
  // Measured quantities, 0.01 x In
  input  wire [IW-1:0] phaseL1,
  input  wire [IW-1:0] phaseL2,
  input  wire [IW-1:0] phaseL3,
  input  wire [IW-1:0] measuredResidualCurrent,
  input  wire [IW-1:0] calcResidualCurrent,
  input  wire [IW-1:0] positiveSequenceCurrent,
  input  wire [IW-1:0] negativeSequenceCurrent,
  // System inputs
  input  wire          blockIn,
  input  wire [31:0]   timeStampMs,
  input  wire [2:0]    settingGroup,
  // Register port
  input  wire [7:0]    regAddr,
  input  wire [31:0]   regWdata,
  input  wire          regWr,
  input  wire          regRd,
  output reg  [31:0]   regRdata_q,
  // Indications
  output reg           alarmOut_q,
  output reg           blockedOut_q,
  output reg           irq_q,
  // Event stream
  output reg           eventValid_q,
  output reg  [3:0]    eventFlags_q,
  output reg  [31:0]   eventStamp_q
);
  localparam RW = 32 + 2 + 4 + 3 + 6 * IW + DW;

  ////////////////////////////////////////////////////////////////////
  // Registers
  reg  [2:0]    ctrl_q;
  reg  [IW-1:0] overcurrentInhibitLimit_q;
  reg  [IW-1:0] minimumCurrentLimit_q;
  reg  [13:0]   minMaxRatioThreshold_q;
  reg  [13:0]   sequenceRatioThreshold_q;
  reg  [IW-1:0] residualMismatchLimit_q;
  reg  [DW-1:0] alarmDelay_q;
  reg  [7:0]    eventSelect_q;
  reg  [3:0]    irqStatus_q;
  reg  [3:0]    irqMask_q;
  reg  [15:0]   alarmCount_q;
  reg  [15:0]   blockCount_q;
  reg  [3:0]    histSel_q;
  // Supervision state
  reg  [31:0]   stepCnt_q;
  reg           tick_q;
  reg  [DW-1:0] timer_q;
  reg           pickup_q;
  reg  [3:0]    faultCode_q;
  reg           alarmD;
  reg           blockD;
  reg  [DW-1:0] timerD;
  reg  [31:0]   rdD;
  wire          wrHit;
  wire          cntClr;
  wire [IW-1:0] phMax;
  wire [IW-1:0] phMin;
  wire [IW-1:0] resDiff;
  wire          overCur;
  wire          underMin;
  wire          ratioMet;
  wire          seqMet;
  wire          resMet;
  wire          pickup;
  wire [3:0]    ev;
  wire [3:0]    evSel;
  wire [DW-1:0] timeLeft;
  wire          histWr;
  wire [RW-1:0] histIn;
  wire [RW-1:0] histOut;
  wire [3:0]    histCnt;
  wire [DW-1:0] hTta;
  wire [IW-1:0] hI2;
  wire [IW-1:0] hI1;
  wire [IW-1:0] hI0;
  wire [IW-1:0] hL3;
  wire [IW-1:0] hL2;
  wire [IW-1:0] hL1;
  wire [2:0]    hGrp;
  wire [3:0]    hFlt;
  wire [1:0]    hCode;
  wire [31:0]   hStamp;

  ////////////////////////////////////////////////////////////////////
  // Program cycle strobe, one clock every 5 ms
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stepCnt_q <= 32'h0;
      tick_q    <= 1'b0;
    end
    else if (stepCnt_q == STEP_CYC - 1)
    begin
      stepCnt_q <= 32'h0;
      tick_q    <= 1'b1;
    end
    else
    begin
      stepCnt_q <= stepCnt_q + 32'h1;
      tick_q    <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pick-up conditions, computed from the latest inputs
  assign phMax = (phaseL1 > phaseL2) ? ((phaseL1 > phaseL3) ? phaseL1 : phaseL3)
                                     : ((phaseL2 > phaseL3) ? phaseL2 : phaseL3);
  assign phMin = (phaseL1 < phaseL2) ? ((phaseL1 < phaseL3) ? phaseL1 : phaseL3)
                                     : ((phaseL2 < phaseL3) ? phaseL2 : phaseL3);
  assign overCur  = phMax > overcurrentInhibitLimit_q;
  assign underMin = phMax < minimumCurrentLimit_q;
  // Magnitude difference of calculated and measured residual
  assign resDiff = (calcResidualCurrent > measuredResidualCurrent)
                 ? calcResidualCurrent - measuredResidualCurrent
                 : measuredResidualCurrent - calcResidualCurrent;
  assign resMet  = resDiff >= residualMismatchLimit_q;

  cts_ratio_cmp #(
    .IW (IW),
    .TW (14),
    .GE (0)
  ) uMinMax (
    .num   (phMin),
    .den   (phMax),
    .thr   (minMaxRatioThreshold_q),
    .meets (ratioMet)
  );

  cts_ratio_cmp #(
    .IW (IW),
    .TW (14),
    .GE (1)
  ) uSeq (
    .num   (negativeSequenceCurrent),
    .den   (positiveSequenceCurrent),
    .thr   (sequenceRatioThreshold_q),
    .meets (seqMet)
  );

  // No side discrimination: pick-up needs the full set of met conditions
  assign pickup = ctrl_q[`CTS_CTRL_EN] & ~overCur & ~underMin & ratioMet & seqMet
                & (~ctrl_q[`CTS_CTRL_RESEN] | resMet);

  ////////////////////////////////////////////////////////////////////
  // Next supervision state, only on a program cycle
  always @*
  begin
    alarmD = alarmOut_q;
    blockD = blockedOut_q;
    timerD = timer_q;
    if (tick_q)
    begin
      if (pickup && blockIn)
      begin
        // Block wins over a running start; timer restarts later
        blockD = 1'b1;
        alarmD = 1'b0;
        timerD = {DW{1'b0}};
      end
      else if (pickup)
      begin
        blockD = 1'b0;
        if (!alarmOut_q)
        begin
          if (timer_q + 1'b1 >= alarmDelay_q)
            alarmD = 1'b1;
          else
            timerD = timer_q + 1'b1;
        end
      end
      else
      begin
        blockD = 1'b0;
        alarmD = 1'b0;
        timerD = {DW{1'b0}};
      end
    end
  end

  // Edges of alarm and block form the four events
  assign ev[`CTS_EV_ALMON]  = alarmD & ~alarmOut_q;
  assign ev[`CTS_EV_ALMOFF] = ~alarmD & alarmOut_q;
  assign ev[`CTS_EV_BLKON]  = blockD & ~blockedOut_q;
  assign ev[`CTS_EV_BLKOFF] = ~blockD & blockedOut_q;
  // Select bits: low nibble enables ON events, high nibble OFF events
  assign evSel = ev & {eventSelect_q[5], eventSelect_q[1],
                       eventSelect_q[4], eventSelect_q[0]};
  assign timeLeft = alarmDelay_q - timer_q;

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      alarmOut_q   <= 1'b0;
      blockedOut_q <= 1'b0;
      timer_q      <= {DW{1'b0}};
      pickup_q     <= 1'b0;
      faultCode_q  <= 4'h0;
      eventValid_q <= 1'b0;
      eventFlags_q <= 4'h0;
      eventStamp_q <= 32'h0;
    end
    else
    begin
      alarmOut_q   <= alarmD;
      blockedOut_q <= blockD;
      timer_q      <= timerD;
      eventValid_q <= |evSel;
      eventFlags_q <= evSel;
      if (|evSel)
        eventStamp_q <= timeStampMs;
      if (tick_q)
      begin
        pickup_q    <= pickup;
        faultCode_q <= {resMet, seqMet & ratioMet, underMin, overCur};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // History of asserting events
  assign histWr = ev[`CTS_EV_ALMON] | ev[`CTS_EV_BLKON];
  assign histIn = {timeLeft, negativeSequenceCurrent, positiveSequenceCurrent,
                   measuredResidualCurrent, phaseL3, phaseL2, phaseL1,
                   settingGroup, resMet, seqMet & ratioMet, underMin, overCur,
                   ev[`CTS_EV_BLKON] ? 2'h2 : 2'h0, timeStampMs};
  assign {hTta, hI2, hI1, hI0, hL3, hL2, hL1, hGrp, hFlt, hCode, hStamp} = histOut;

  cts_history #(
    .RW    (RW),
    .DEPTH (`CTS_HIST_DEPTH)
  ) uHist (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .wrEn    (histWr),
    .wrData  (histIn),
    .rdIdx   (histSel_q),
    .rdData  (histOut),
    .entries (histCnt)
  );

  ////////////////////////////////////////////////////////////////////
  // Register writes; hardware set wins over a software clear
  assign wrHit  = regWr;
  assign cntClr = wrHit && regAddr == `CTS_OFF_CTRL && regWdata[`CTS_CTRL_CNTCLR];

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q                    <= `CTS_RST_CTRL;
      overcurrentInhibitLimit_q <= `CTS_RST_HIGH;
      minimumCurrentLimit_q     <= `CTS_RST_LOW;
      minMaxRatioThreshold_q    <= `CTS_RST_MINMAX;
      sequenceRatioThreshold_q  <= `CTS_RST_SEQ;
      residualMismatchLimit_q   <= `CTS_RST_RESID;
      alarmDelay_q              <= `CTS_RST_DELAY;
      eventSelect_q             <= `CTS_RST_EVSEL;
      irqMask_q                 <= 4'h0;
      histSel_q                 <= 4'h0;
      irqStatus_q               <= 4'h0;
    end
    else
    begin
      if (wrHit)
      begin
        case (regAddr)
          `CTS_OFF_CTRL:   ctrl_q <= {1'b0, regWdata[1:0]};
          `CTS_OFF_HIGH:   overcurrentInhibitLimit_q <= regWdata[IW-1:0];
          `CTS_OFF_LOW:    minimumCurrentLimit_q <= regWdata[IW-1:0];
          `CTS_OFF_MINMAX: minMaxRatioThreshold_q <= regWdata[13:0];
          `CTS_OFF_SEQ:    sequenceRatioThreshold_q <= regWdata[13:0];
          `CTS_OFF_RESID:  residualMismatchLimit_q <= regWdata[IW-1:0];
          `CTS_OFF_DELAY:  alarmDelay_q <= regWdata[DW-1:0];
          `CTS_OFF_EVSEL:  eventSelect_q <= regWdata[7:0];
          `CTS_OFF_IMASK:  irqMask_q <= regWdata[3:0];
          `CTS_OFF_HSEL:   histSel_q <= regWdata[3:0];
          default:         ;
        endcase
      end
      // Write one to clear, new events set in the same cycle
      irqStatus_q <= (irqStatus_q & ~((wrHit && regAddr == `CTS_OFF_ISTAT)
                     ? regWdata[3:0] : 4'h0)) | ev;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Counters and interrupt; increment wins over a clear
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      alarmCount_q <= 16'h0;
      blockCount_q <= 16'h0;
      irq_q        <= 1'b0;
    end
    else
    begin
      alarmCount_q <= (cntClr ? 16'h0 : alarmCount_q)
                    + {15'h0, ev[`CTS_EV_ALMON]};
      blockCount_q <= (cntClr ? 16'h0 : blockCount_q)
                    + {15'h0, ev[`CTS_EV_BLKON]};
      irq_q        <= |(irqStatus_q & irqMask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read mux; unmapped offsets read zero
  always @*
  begin
    rdD = 32'h0;
    case (regAddr)
      `CTS_OFF_CTRL:   rdD = {30'h0, ctrl_q[1:0]};
      `CTS_OFF_HIGH:   rdD = {{(32-IW){1'b0}}, overcurrentInhibitLimit_q};
      `CTS_OFF_LOW:    rdD = {{(32-IW){1'b0}}, minimumCurrentLimit_q};
      `CTS_OFF_MINMAX: rdD = {18'h0, minMaxRatioThreshold_q};
      `CTS_OFF_SEQ:    rdD = {18'h0, sequenceRatioThreshold_q};
      `CTS_OFF_RESID:  rdD = {{(32-IW){1'b0}}, residualMismatchLimit_q};
      `CTS_OFF_DELAY:  rdD = {{(32-DW){1'b0}}, alarmDelay_q};
      `CTS_OFF_EVSEL:  rdD = {24'h0, eventSelect_q};
      `CTS_OFF_STATUS: rdD = {21'h0, histCnt, faultCode_q, pickup_q,
                              blockedOut_q, alarmOut_q};
      `CTS_OFF_ISTAT:  rdD = {28'h0, irqStatus_q};
      `CTS_OFF_IMASK:  rdD = {28'h0, irqMask_q};
      `CTS_OFF_ALMCNT: rdD = {16'h0, alarmCount_q};
      `CTS_OFF_BLKCNT: rdD = {16'h0, blockCount_q};
      `CTS_OFF_HSEL:   rdD = {28'h0, histSel_q};
      `CTS_OFF_HTIME:  rdD = hStamp;
      `CTS_OFF_HINFO:  rdD = {23'h0, hGrp, hFlt, hCode};
      `CTS_OFF_HPH12:  rdD = {hL2, hL1};
      `CTS_OFF_HPH3R:  rdD = {hI0, hL3};
      `CTS_OFF_HSEQ:   rdD = {hI2, hI1};
      `CTS_OFF_HTTA:   rdD = {{(32-DW){1'b0}}, hTta};
      default:         rdD = 32'h0;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      regRdata_q <= 32'h0;
    else if (regRd)
      regRdata_q <= rdD;
    else
      regRdata_q <= 32'h0;
  end
endmodule
`default_nettype wire

// ==== verif/cts_meas_model.sv ====
`default_nettype none
// Stands in for the phase and residual measurement channels and the blocking matrix
module cts_meas_model (
  // Clock
  input  wire logic        sys_clk,
  // Scenario selection from the bench
  input  wire logic [2:0]  mode,
  input  wire logic        blkReq,
  // Measured quantities, 0.01 x In
  output var  logic [15:0] phaseL1,
  output var  logic [15:0] phaseL2,
  output var  logic [15:0] phaseL3,
  output var  logic [15:0] posSeq,
  output var  logic [15:0] negSeq,
  output var  logic [15:0] calcRes,
  output var  logic [15:0] measRes,
  // Blocking input
  output var  logic        blockIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] modeQ = 3'h0;
  logic       blkQ  = 1'b0;

  // Channels move one clock after the bench asks, like a fresh measurement frame
  always_ff @(posedge sys_clk)
  begin
    modeQ <= mode;
    blkQ  <= blkReq;
  end

  // Block is raised together with the faulty currents, long before the delay runs out
  always_comb blockIn = blkQ;

  // Each mode is one of the typical wiring situations
  always_comb
  begin
    case (modeQ)
      3'h1: {phaseL1, phaseL2, phaseL3, posSeq, negSeq, calcRes, measRes} =
            {16'h0000, 16'h0064, 16'h0064, 16'h0043, 16'h0021, 16'h0064, 16'h0000};
      3'h2: {phaseL1, phaseL2, phaseL3, posSeq, negSeq, calcRes, measRes} =
            {16'h0000, 16'h00C8, 16'h00C8, 16'h0085, 16'h0043, 16'h00C8, 16'h0000};
      3'h3: {phaseL1, phaseL2, phaseL3, posSeq, negSeq, calcRes, measRes} =
            {16'h0000, 16'h0005, 16'h0005, 16'h0003, 16'h0002, 16'h0005, 16'h0000};
      3'h4: {phaseL1, phaseL2, phaseL3, posSeq, negSeq, calcRes, measRes} =
            {16'h0000, 16'h0064, 16'h0064, 16'h0043, 16'h0021, 16'h0064, 16'h0064};
      default: {phaseL1, phaseL2, phaseL3, posSeq, negSeq, calcRes, measRes} =
            {16'h0064, 16'h0064, 16'h0064, 16'h0064, 16'h0000, 16'h0000, 16'h0000};
    endcase
  end
endmodule
`default_nettype wire

// ==== verif/cts_monitor.sv ====
`default_nettype none
// Watches the indications and the event stream of the supervision block
module cts_monitor #(
  parameter int STEP_CYC = 500000
) (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // Inputs of interest
  input wire logic        blockIn,
  input wire logic [31:0] timeStampMs,
  // Indications and events
  input wire logic        alarmOut_q,
  input wire logic        blockedOut_q,
  input wire logic        eventValid_q,
  input wire logic [3:0]  eventFlags_q,
  input wire logic [31:0] eventStamp_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  logic        almPrev_q;
  logic        blkPrev_q;
  logic [31:0] gap_q;

  // Cycles since either indication last moved; they may only move once per tick
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      almPrev_q <= 1'b0;
      blkPrev_q <= 1'b0;
      gap_q     <= 32'h0;
    end
    else
    begin
      almPrev_q <= alarmOut_q;
      blkPrev_q <= blockedOut_q;
      gap_q     <= (alarmOut_q != almPrev_q || blockedOut_q != blkPrev_q) ? 32'h0 : gap_q + 1;
    end
  end

  sequence almOnEv;  eventValid_q && eventFlags_q[0]; endsequence
  sequence almOffEv; eventValid_q && eventFlags_q[1]; endsequence
  sequence blkOnEv;  eventValid_q && eventFlags_q[2]; endsequence

  // Alarm and blocked never stand together
  alarm_block_excl_a: assert property (!(alarmOut_q && blockedOut_q))
    else $error("alarm and blocked both high");
  event_one_pulse_a: assert property (eventValid_q |=> !eventValid_q)
    else $error("event pulse longer than one cycle");
  alarm_on_event_a: assert property (almOnEv |-> $rose(alarmOut_q))
    else $error("alarm-on event without alarm rising");
  alarm_off_event_a: assert property (almOffEv |-> $fell(alarmOut_q))
    else $error("alarm-off event without alarm falling");
  block_on_event_a: assert property (blkOnEv |-> $rose(blockedOut_q))
    else $error("block-on event without blocked rising");
  stamp_capture_a: assert property (eventValid_q |-> eventStamp_q == $past(timeStampMs))
    else $error("event stamp not taken from time input");
  stamp_hold_a: assert property (!eventValid_q |-> $stable(eventStamp_q))
    else $error("event stamp moved without an event");
  tick_spacing_a: assert property (
    (alarmOut_q != almPrev_q || blockedOut_q != blkPrev_q) |-> gap_q >= STEP_CYC - 1)
    else $error("indication changed between program ticks");
  alarm_unblocked_a: assert property ($rose(alarmOut_q) |-> !$past(blockIn))
    else $error("alarm raised while block input high");
  block_cause_a: assert property ($rose(blockedOut_q) |-> $past(blockIn))
    else $error("blocked raised without block input");
endmodule

bind cts_supervision cts_monitor #(.STEP_CYC(STEP_CYC)) MON (.sys_clk, .rst_n, .blockIn,
  .timeStampMs, .alarmOut_q, .blockedOut_q, .eventValid_q, .eventFlags_q, .eventStamp_q);
`default_nettype wire

// ==== verif/cts_tb_top.sv ====
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STEP = 20;
  localparam int DLY  = 3;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [2:0]  mode = 3'h0;
  logic        blkReq = 1'b0;
  logic [31:0] timeStampMs = 32'h0;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [15:0] phaseL1, phaseL2, phaseL3, posSeq, negSeq, calcRes, measRes;
  logic        blockIn, alarmOut_q, blockedOut_q, irq_q, eventValid_q;
  logic [31:0] regRdata_q, eventStamp_q;
  logic [3:0]  eventFlags_q;
  int          failures = 0;
  int          nTests = 0;
  int          cyc = 0;

  cts_meas_model MEAS (.sys_clk, .mode, .blkReq, .phaseL1, .phaseL2, .phaseL3, .posSeq,
    .negSeq, .calcRes, .measRes, .blockIn);
  cts_supervision #(.STEP_CYC(STEP)) DUT (.sys_clk, .rst_n, .phaseL1, .phaseL2, .phaseL3,
    .measuredResidualCurrent(measRes), .calcResidualCurrent(calcRes),
    .positiveSequenceCurrent(posSeq), .negativeSequenceCurrent(negSeq), .blockIn,
    .timeStampMs, .settingGroup(3'h2), .regAddr, .regWdata, .regWr, .regRd, .regRdata_q,
    .alarmOut_q, .blockedOut_q, .irq_q, .eventValid_q, .eventFlags_q, .eventStamp_q);

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog; the limit is far above the sum of all scenario waits
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (failures == 0 && nTests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    nTests++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Register port: strobes one cycle long, read data stands in the next cycle only
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 d = regRdata_q;
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d & m, e, "register read");
  endtask

  // Waits for an event pulse under a bound; n is the cycle count, 0 if none came
  task automatic waitEv(input int lim, output int n);
    n = 0;
    for (int i = 1; i <= lim && n == 0; i++)
    begin
      @(posedge sys_clk);
      #1 if (eventValid_q === 1'b1) n = i;
    end
  endtask

  task automatic evChk(input logic [2:0] m, input logic [3:0] f, input string what);
    int n;
    mode <= m;
    waitEv(4 * DLY * STEP, n);
    chk({28'h0, eventFlags_q}, {28'h0, f}, what);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    logic [7:0]  a[5] = '{8'h00, 8'h04, 8'h18, 8'h1C, 8'hFC};
    logic [31:0] e[5] = '{32'h1, 32'h78, 32'h64, 32'hFF, 32'h0};
    foreach (a[i]) rdChk(a[i], 32'hFFFFFFFF, e[i]);
  endtask

  task automatic t_alarm();
    int n;
    timeStampMs <= 32'h0000_1234;
    mode <= 3'h1;
    waitEv(4 * DLY * STEP, n);
    chk({31'h0, n >= (DLY - 1) * STEP && n <= DLY * STEP + 3}, 32'h1, "delay");
    chk({28'h0, eventFlags_q}, 32'h1, "alarm on flags");
    chk({31'h0, alarmOut_q}, 32'h1, "alarm");
    chk(eventStamp_q, 32'h0000_1234, "stamp");
    repeat (3) @(posedge sys_clk);
    #1 chk({31'h0, irq_q}, 32'h1, "irq raised");
    rdChk(8'h2C, 32'hFFFF, 32'h1);
    rdChk(8'h40, 32'hFFFFFFFF, 32'h0064_0000);
    rdChk(8'h3C, 32'h1C3, 32'h080);
    wr(8'h24, 32'h1);
    repeat (3) @(posedge sys_clk);
    #1 chk({31'h0, irq_q}, 32'h0, "irq cleared");
  endtask

  task automatic t_release();
    evChk(3'h0, 4'h2, "alarm off flags");
    chk({31'h0, alarmOut_q}, 32'h0, "alarm dropped");
    repeat (3) @(posedge sys_clk);
    #1 chk({31'h0, irq_q}, 32'h0, "masked status");
  endtask

  task automatic t_block();
    blkReq <= 1'b1;
    evChk(3'h1, 4'h4, "block on flags");
    chk({30'h0, blockedOut_q, alarmOut_q}, 32'h2, "blocked only");
    blkReq <= 1'b0;
    evChk(3'h0, 4'h8, "block off flags");
    rdChk(8'h30, 32'hFFFF, 32'h1);
  endtask

  task automatic t_inhibit();
    int n;
    for (int m = 2; m <= 3; m++)
    begin
      mode <= m[2:0];
      waitEv(4 * DLY * STEP, n);
      chk(n, 0, "inhibited pickup");
    end
    mode <= 3'h0;
  endtask

  task automatic t_resid();
    int n;
    wr(8'h00, 32'h3);
    mode <= 3'h4;
    waitEv(4 * DLY * STEP, n);
    chk(n, 0, "residual match");
    evChk(3'h1, 4'h1, "residual mismatch");
    evChk(3'h0, 4'h2, "residual release");
    wr(8'h00, 32'h1);
  endtask

  task automatic t_evsel();
    int n;
    wr(8'h1C, 32'h1);
    evChk(3'h1, 4'h1, "selected rise");
    mode <= 3'h0;
    waitEv(3 * STEP, n);
    chk(n, 0, "unselected fall");
    chk({31'h0, alarmOut_q}, 32'h0, "alarm dropped");
    wr(8'h1C, 32'hFF);
  endtask

  task automatic t_clear();
    rdChk(8'h2C, 32'hFFFF, 32'h3);
    wr(8'h00, 32'h5);
    rdChk(8'h2C, 32'hFFFF, 32'h0);
  endtask

  // Four earlier records plus nine blocks overflow the ring by one
  task automatic t_hist();
    for (int i = 0; i < 9; i++)
    begin
      @(posedge sys_clk);
      timeStampMs <= i;
      blkReq <= 1'b1;
      evChk(3'h1, 4'h4, "block on flags");
      blkReq <= 1'b0;
      evChk(3'h0, 4'h8, "block off flags");
    end
    rdChk(8'h20, 32'h787, 32'h600);
    rdChk(8'h38, 32'hFFFFFFFF, 32'h8);
    wr(8'h34, 32'hB);
    rdChk(8'h3C, 32'h3, 32'h2);
    wr(8'h34, 32'hC);
    rdChk(8'h38, 32'hFFFFFFFF, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_defaults();
    wr(8'h18, DLY);
    wr(8'h28, 32'h1);
    t_alarm();
    t_release();
    t_block();
    t_inhibit();
    t_resid();
    t_evsel();
    t_clear();
    t_hist();
    wrap_up();
  end
endmodule
`default_nettype wire
